//--- include/sysref_clock_control_defines.svh
`ifndef SYSREF_CLOCK_CONTROL_DEFINES_SVH
`define SYSREF_CLOCK_CONTROL_DEFINES_SVH

// ==========================================
// Register offsets
`define CC_ADDR_A 15'h0029
`define CC_ADDR_B 15'h002A
`define CC_ADDR_C 15'h002B
`define CC_ADDR_POS0 15'h002C
`define CC_ADDR_POS1 15'h002D
`define CC_ADDR_POS2 15'h002E

// ==========================================
// Reset values
`define CC_RESET_A 8'h00
`define CC_RESET_B 8'h00
`define CC_RESET_C 8'h11
`define CC_READ_UNMAPPED 8'h00

// ==========================================
// Field positions
`define CA_PROC_EN_BIT 6
`define CA_RECV_EN_BIT 5
`define CA_FINE_SCALE_BIT 4
`define CA_DELAY_MSB 3
`define CA_DELAY_LSB 0
`define CB_TIMESTAMP_BIT 3
`define CB_DEVCLK_PECL_BIT 2
`define CB_SYSREF_PECL_BIT 1
`define CB_INVERT_BIT 0
`define CC_FB_GAIN_BIT 4
`define CC_NOISE_SUPPR_BIT 2
`define CC_SAMPLE_DELAY_MSB 1
`define CC_SAMPLE_DELAY_LSB 0

// ==========================================
// Serial frame timing
`define SPI_HDR_LAST 4'hF
`define SPI_BYTE_LAST 3'h7

`endif

//--- include/sysref_clock_control_pkg.sv
package sysref_clock_control_pkg;

	typedef enum logic [1:0]
	{
		SPI_IDLE = 2'b00,
		SPI_HEADER = 2'b01,
		SPI_DATA = 2'b10
	} spi_state_t;

	typedef struct packed
	{
		logic wr;
		logic [14:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed
	{
		logic receiver_enable;
		logic processor_enable;
		logic window_fine_scale;
		logic [3:0] delay_choice;
		logic polarity_invert;
		logic pecl_mode;
	} sysref_ctrl_t;

	typedef struct packed
	{
		logic device_clock_pecl_mode;
		logic converter_feedback_gain;
		logic supply_noise_suppress;
		logic [1:0] sample_clock_delay;
	} clock_ctrl_t;

endpackage

//--- src/serial_reg_port.sv
`timescale 1ns/100ps
`include "sysref_clock_control_defines.svh"

module serial_reg_port
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Serial pins
	input wire logic sclk_in,
	input wire logic sen_b_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// Register side
	output sysref_clock_control_pkg::reg_req_t req_out,
	output logic [14:0] rd_addr_out,
	input wire logic [7:0] rd_data_in
);
	import sysref_clock_control_pkg::*;

	// ==========================================
	// Pin synchronisers
	// Third stage only feeds edge detection; stage 0 is read by stage 1 alone
	logic [2:0] sclk_s_r;
	logic [1:0] sen_s_r;
	logic [1:0] sdi_s_r;
	logic rise;
	logic fall;
	logic sel;

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sclk_s_r <= 3'h0;
			sen_s_r <= 2'h3;
			sdi_s_r <= 2'h0;
		end
		else
		begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_in};
			sen_s_r <= {sen_s_r[0], sen_b_in};
			sdi_s_r <= {sdi_s_r[0], sdi_in};
		end
	end

	assign rise = sclk_s_r[1] & ~sclk_s_r[2];
	assign fall = ~sclk_s_r[1] & sclk_s_r[2];
	assign sel = ~sen_s_r[1];

	// ==========================================
	// Frame state: R/W bit, 15-bit address, then data bytes with ascending address
	spi_state_t state_r, state_nxt;
	logic [3:0] hdr_cnt_r, hdr_cnt_nxt;
	logic [2:0] bit_pos_r, bit_pos_nxt;
	logic [15:0] hdr_sh_r, hdr_sh_nxt;
	logic rw_r, rw_nxt;
	logic [14:0] addr_r, addr_nxt;
	logic [7:0] wsh_r, wsh_nxt;
	logic [7:0] osh_r, osh_nxt;
	logic sdo_r, sdo_nxt;
	reg_req_t req_r, req_nxt;

	always_comb
	begin
		state_nxt = state_r;
		hdr_cnt_nxt = hdr_cnt_r;
		bit_pos_nxt = bit_pos_r;
		hdr_sh_nxt = hdr_sh_r;
		rw_nxt = rw_r;
		addr_nxt = addr_r;
		wsh_nxt = wsh_r;
		osh_nxt = osh_r;
		req_nxt = req_r;
		req_nxt.wr = 1'b0;
		if (!sel)
		begin
			state_nxt = SPI_IDLE;
			hdr_cnt_nxt = 4'h0;
			bit_pos_nxt = 3'h0;
		end
		else
		begin
			case (state_r)
				SPI_IDLE:
				begin
					state_nxt = SPI_HEADER;
				end
				SPI_HEADER:
				begin
					if (rise)
					begin
						hdr_sh_nxt = {hdr_sh_r[14:0], sdi_s_r[1]};
						hdr_cnt_nxt = hdr_cnt_r + 4'h1;
						if (hdr_cnt_r == `SPI_HDR_LAST)
						begin
							rw_nxt = hdr_sh_r[14];
							addr_nxt = {hdr_sh_r[13:0], sdi_s_r[1]};
							bit_pos_nxt = 3'h0;
							state_nxt = SPI_DATA;
						end
					end
				end
				SPI_DATA:
				begin
					if (rise)
					begin
						wsh_nxt = {wsh_r[6:0], sdi_s_r[1]};
						bit_pos_nxt = bit_pos_r + 3'h1;
						if (bit_pos_r == `SPI_BYTE_LAST)
						begin
							req_nxt.wr = ~rw_r;
							req_nxt.addr = addr_r;
							req_nxt.wdata = {wsh_r[6:0], sdi_s_r[1]};
							addr_nxt = addr_r + 15'h0001;
						end
					end
					// Load on the fall ahead of each byte so its MSB is ready for the next rise
					if (fall)
					begin
						if (bit_pos_r == 3'h0)
							osh_nxt = rd_data_in;
						else
							osh_nxt = {osh_r[6:0], 1'b0};
					end
				end
				default:
				begin
					state_nxt = SPI_IDLE;
				end
			endcase
		end
		sdo_nxt = (state_nxt == SPI_DATA) && rw_nxt && osh_nxt[7];
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_r <= SPI_IDLE;
			hdr_cnt_r <= 4'h0;
			bit_pos_r <= 3'h0;
			hdr_sh_r <= 16'h0000;
			rw_r <= 1'b0;
			addr_r <= 15'h0000;
			wsh_r <= 8'h00;
			osh_r <= 8'h00;
			sdo_r <= 1'b0;
			req_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			hdr_cnt_r <= hdr_cnt_nxt;
			bit_pos_r <= bit_pos_nxt;
			hdr_sh_r <= hdr_sh_nxt;
			rw_r <= rw_nxt;
			addr_r <= addr_nxt;
			wsh_r <= wsh_nxt;
			osh_r <= osh_nxt;
			sdo_r <= sdo_nxt;
			req_r <= req_nxt;
		end
	end

	assign sdo_out = sdo_r;
	assign req_out = req_r;
	assign rd_addr_out = addr_r;

endmodule

//--- src/sysref_clock_control_regs.sv
`timescale 1ns/100ps
`include "sysref_clock_control_defines.svh"

module sysref_clock_control_regs
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Serial register port
	input wire logic sclk_in,
	input wire logic sen_b_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// SYSREF and status from the analog front end
	input wire logic sysref_in,
	input wire logic [23:0] sysref_edge_position_in,
	// Datapath mode, same clock domain
	input wire logic timestamp_marking_enable_in,
	input wire logic decimation_is_one_in,
	// Configuration towards the clock and SYSREF circuits
	output sysref_clock_control_pkg::sysref_ctrl_t sysref_cfg_out,
	output sysref_clock_control_pkg::clock_ctrl_t clock_cfg_out,
	// SYSREF results
	output logic sysref_event_out,
	output logic sample_lsb_timestamp_out
);
	import sysref_clock_control_pkg::*;

	// ==========================================
	// Serial port
	reg_req_t req;
	logic [14:0] rd_addr;
	logic [7:0] rd_data;

	serial_reg_port u_port
	(
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.sclk_in(sclk_in),
		.sen_b_in(sen_b_in),
		.sdi_in(sdi_in),
		.sdo_out(sdo_out),
		.req_out(req),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	// ==========================================
	// Registers
	// Whole bytes are stored so reserved bits read back as written
	logic [7:0] ca_r;
	logic [7:0] cb_r;
	logic [7:0] cc_r;
	logic wr_a;
	logic wr_b;
	logic wr_c;

	assign wr_a = req.wr && (req.addr == `CC_ADDR_A);
	assign wr_b = req.wr && (req.addr == `CC_ADDR_B);
	assign wr_c = req.wr && (req.addr == `CC_ADDR_C);

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ca_r <= `CC_RESET_A;
			cb_r <= `CC_RESET_B;
			cc_r <= `CC_RESET_C;
		end
		else
		begin
			if (wr_a)
				ca_r <= req.wdata;
			if (wr_b)
				cb_r <= req.wdata;
			if (wr_c)
				cc_r <= req.wdata;
		end
	end

	// ==========================================
	// Edge position status
	// Bits are synchronised one by one; a read during an update may mix old and new bits
	logic [23:0] pos_s1_r;
	logic [23:0] pos_s2_r;

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pos_s1_r <= 24'h00_0000;
			pos_s2_r <= 24'h00_0000;
		end
		else
		begin
			pos_s1_r <= sysref_edge_position_in;
			pos_s2_r <= pos_s1_r;
		end
	end

	// ==========================================
	// Read decode
	assign rd_data = (rd_addr == `CC_ADDR_A) ? ca_r :
		(rd_addr == `CC_ADDR_B) ? cb_r :
		(rd_addr == `CC_ADDR_C) ? cc_r :
		(rd_addr == `CC_ADDR_POS0) ? pos_s2_r[7:0] :
		(rd_addr == `CC_ADDR_POS1) ? pos_s2_r[15:8] :
		(rd_addr == `CC_ADDR_POS2) ? pos_s2_r[23:16] :
		`CC_READ_UNMAPPED;

	// ==========================================
	// Configuration outputs
	logic recv_en;
	logic proc_en;
	logic invert;
	logic ts_en;

	assign recv_en = ca_r[`CA_RECV_EN_BIT];
	assign proc_en = ca_r[`CA_PROC_EN_BIT];
	assign invert = cb_r[`CB_INVERT_BIT];
	assign ts_en = cb_r[`CB_TIMESTAMP_BIT];

	assign sysref_cfg_out.receiver_enable = recv_en;
	assign sysref_cfg_out.processor_enable = proc_en;
	assign sysref_cfg_out.window_fine_scale = ca_r[`CA_FINE_SCALE_BIT];
	assign sysref_cfg_out.delay_choice = ca_r[`CA_DELAY_MSB:`CA_DELAY_LSB];
	assign sysref_cfg_out.polarity_invert = invert;
	assign sysref_cfg_out.pecl_mode = cb_r[`CB_SYSREF_PECL_BIT];
	assign clock_cfg_out.device_clock_pecl_mode = cb_r[`CB_DEVCLK_PECL_BIT];
	assign clock_cfg_out.converter_feedback_gain = cc_r[`CC_FB_GAIN_BIT];
	assign clock_cfg_out.supply_noise_suppress = cc_r[`CC_NOISE_SUPPR_BIT];
	assign clock_cfg_out.sample_clock_delay = cc_r[`CC_SAMPLE_DELAY_MSB:`CC_SAMPLE_DELAY_LSB];

	// ==========================================
	// SYSREF path
	// The processor enable alone does nothing with the receiver off, so events need both
	logic [1:0] sr_s_r;
	logic aligned_r;
	logic aligned_d_r;
	logic event_r;
	logic ts_r;
	logic ts_allowed;

	assign ts_allowed = ts_en && timestamp_marking_enable_in && decimation_is_one_in;

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sr_s_r <= 2'h0;
			aligned_r <= 1'b0;
			aligned_d_r <= 1'b0;
			event_r <= 1'b0;
			ts_r <= 1'b0;
		end
		else
		begin
			sr_s_r <= {sr_s_r[0], sysref_in};
			aligned_r <= recv_en & (sr_s_r[1] ^ invert);
			aligned_d_r <= aligned_r;
			event_r <= proc_en & recv_en & aligned_r & ~aligned_d_r;
			ts_r <= ts_allowed & aligned_r;
		end
	end

	assign sysref_event_out = event_r;
	assign sample_lsb_timestamp_out = ts_r;

	// ==========================================
	// Assertions
	AST_EVENT_NEEDS_PROC: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		sysref_event_out |-> $past(proc_en) && $past(recv_en) && $past(aligned_r))
		else $error("SYSREF event without processor and receiver enabled");

	AST_RESET_VALUES: assert property (@(posedge clock_in)
		$rose(rst_b_in) |-> (ca_r == `CC_RESET_A) && (cb_r == `CC_RESET_B)
			&& (cc_r == `CC_RESET_C))
		else $error("Register reset values wrong");

	AST_RECV_OFF_QUIET: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		!recv_en ##1 !recv_en |=> !aligned_r && !sysref_event_out)
		else $error("SYSREF passes with receiver disabled");

	AST_POLARITY: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		recv_en |=> aligned_r == ($past(sr_s_r[1]) ^ $past(invert)))
		else $error("SYSREF polarity not applied");

	AST_TIMESTAMP_CAUSE: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		sample_lsb_timestamp_out |-> $past(ts_en) && $past(timestamp_marking_enable_in)
			&& $past(aligned_r))
		else $error("Timestamp LSB set without both enables");

	AST_TIMESTAMP_DECIM: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		!decimation_is_one_in |=> !sample_lsb_timestamp_out)
		else $error("Timestamp LSB driven with decimation active");

	AST_WRITE_A: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		wr_a |=> ca_r == $past(req.wdata) ##1 (rd_addr != `CC_ADDR_A || rd_data == ca_r))
		else $error("clock_control_a write not stored");

	AST_WRITE_C: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		wr_c |=> clock_cfg_out.converter_feedback_gain == $past(req.wdata[`CC_FB_GAIN_BIT]))
		else $error("Feedback gain not taken from write");

	AST_STATUS_READ: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(rd_addr == `CC_ADDR_POS2) |-> rd_data == $past(sysref_edge_position_in[23:16], 2))
		else $error("Edge position read wrong");

	AST_WRITE_B: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		wr_b |=> cb_r == $past(req.wdata))
		else $error("clock_control_b write not stored");

	AST_HOLD_REGS: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		!req.wr |=> $stable(ca_r) && $stable(cb_r) && $stable(cc_r))
		else $error("Register changed without a write");

	AST_DELAY_CHOICE: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		wr_a |=> sysref_cfg_out.delay_choice
			== $past(req.wdata[`CA_DELAY_MSB:`CA_DELAY_LSB]))
		else $error("Delay tap choice not taken from write");

	AST_EVENT_ONE_CYCLE: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		sysref_event_out |=> !sysref_event_out)
		else $error("SYSREF event pulse longer than one cycle");

endmodule

//--- testbench/tb_sysref_clock_control_regs.sv
`timescale 1ns/100ps
`include "sysref_clock_control_defines.svh"

module tb_sysref_clock_control_regs;
	import sysref_clock_control_pkg::*;

	// ==========================================
	// Stimulus and observed signals
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic sclk_in = 1'b0;
	logic sen_b_in = 1'b1;
	logic sdi_in = 1'b0;
	logic sysref_in = 1'b0;
	logic [23:0] sysref_edge_position_in = 24'hA5_C396;
	logic timestamp_marking_enable_in = 1'b0;
	logic decimation_is_one_in = 1'b0;
	logic sdo_out;
	sysref_ctrl_t sysref_cfg_out;
	clock_ctrl_t clock_cfg_out;
	logic sysref_event_out;
	logic sample_lsb_timestamp_out;
	int failures = 0;
	int num_checks = 0;
	int events = 0;
	logic [23:0] rd;
	// Proc enable only ever set together with or after receiver enable
	logic [23:0] pat [4] = '{24'hEE_FFA5, 24'h02_0AF0, 24'h15_F53A, 24'h11_0000};

	sysref_clock_control_regs uut
	(
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.sclk_in(sclk_in),
		.sen_b_in(sen_b_in),
		.sdi_in(sdi_in),
		.sdo_out(sdo_out),
		.sysref_in(sysref_in),
		.sysref_edge_position_in(sysref_edge_position_in),
		.timestamp_marking_enable_in(timestamp_marking_enable_in),
		.decimation_is_one_in(decimation_is_one_in),
		.sysref_cfg_out(sysref_cfg_out),
		.clock_cfg_out(clock_cfg_out),
		.sysref_event_out(sysref_event_out),
		.sample_lsb_timestamp_out(sample_lsb_timestamp_out)
	);

	initial
	begin
		forever #12.5 clock_in = ~clock_in;
	end

	// Counts high cycles, so a stretched pulse shows as more than one
	always @(negedge clock_in)
		if (sysref_event_out === 1'b1)
			events++;

	// ==========================================
	// Helpers
	task automatic ticks(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Six clocks per phase leaves margin over the synchroniser latency
	task automatic bit_io(input logic b, output logic s);
		sdi_in = b;
		ticks(6);
		s = sdo_out;
		sclk_in = 1'b1;
		ticks(6);
		sclk_in = 1'b0;
	endtask

	// Byte k of wd and rdv goes to address addr + k
	task automatic xfer(input logic rw, input logic [14:0] addr, input int n,
		input logic [23:0] wd, output logic [23:0] rdv);
		logic s;
		logic [15:0] hdr;
		hdr = {rw, addr};
		rdv = 24'h00_0000;
		sen_b_in = 1'b0;
		ticks(4);
		for (int i = 15; i >= 0; i--)
			bit_io(hdr[i], s);
		for (int k = 0; k < n; k++)
			for (int i = 7; i >= 0; i--)
			begin
				bit_io(wd[8 * k + i], s);
				rdv[8 * k + i] = s;
			end
		ticks(6);
		sen_b_in = 1'b1;
		ticks(6);
	endtask

	function automatic sysref_ctrl_t exp_sys(input logic [7:0] a, input logic [7:0] b);
		return {a[5], a[6], a[4], a[3:0], b[0], b[1]};
	endfunction

	function automatic clock_ctrl_t exp_clk(input logic [7:0] b, input logic [7:0] c);
		return {b[2], c[4], c[2], c[1:0]};
	endfunction

	// Idle level keeps the corrected SYSREF low, then one corrected rise and fall
	task automatic sys_try(input logic [7:0] a, input logic [7:0] b, input int exp);
		xfer(1'b0, `CC_ADDR_A, 2, {8'h00, b, a}, rd);
		sysref_in = b[0];
		ticks(8);
		events = 0;
		sysref_in = ~b[0];
		ticks(8);
		sysref_in = b[0];
		ticks(8);
		check(24'(events), 24'(exp));
	endtask

	task automatic ts_try(input logic [7:0] b, input logic m, input logic d, input logic s,
		input logic exp);
		xfer(1'b0, `CC_ADDR_B, 1, {16'h0000, b}, rd);
		timestamp_marking_enable_in = m;
		decimation_is_one_in = d;
		sysref_in = s;
		ticks(8);
		check(24'(sample_lsb_timestamp_out), 24'(exp));
	endtask

	task automatic reset_values;
		check(24'(sysref_cfg_out), 24'h00_0000);
		check(24'(clock_cfg_out), 24'(exp_clk(`CC_RESET_B, `CC_RESET_C)));
		xfer(1'b1, `CC_ADDR_A, 3, 24'h00_0000, rd);
		check(rd, {`CC_RESET_C, `CC_RESET_B, `CC_RESET_A});
	endtask

	// ==========================================
	// Test sequence
	initial
	begin
		logic s;
		ticks(2);
		rst_b_in = 1'b1;
		ticks(4);
		reset_values();
		foreach (pat[j])
		begin
			xfer(1'b0, `CC_ADDR_A, 3, pat[j], rd);
			xfer(1'b1, `CC_ADDR_A, 3, 24'h00_0000, rd);
			check(rd, pat[j]);
			check(24'(sysref_cfg_out), 24'(exp_sys(pat[j][7:0], pat[j][15:8])));
			check(24'(clock_cfg_out), 24'(exp_clk(pat[j][15:8], pat[j][23:16])));
		end
		// Frame dropped after four data bits must change nothing
		sen_b_in = 1'b0;
		ticks(4);
		for (int i = 15; i >= 0; i--)
			bit_io(i < 15 && `CC_ADDR_A >> i & 1'b1, s);
		repeat (4) bit_io(1'b1, s);
		sen_b_in = 1'b1;
		ticks(8);
		check(24'(sysref_cfg_out), 24'h00_0000);
		xfer(1'b1, `CC_ADDR_POS0, 3, 24'h00_0000, rd);
		check(rd, sysref_edge_position_in);
		xfer(1'b0, `CC_ADDR_POS0, 3, 24'hFF_FFFF, rd);
		xfer(1'b1, `CC_ADDR_POS2, 3, 24'h00_0000, rd);
		check(rd, 24'h00_00A5);
		sys_try(8'h00, 8'h00, 0);
		sys_try(8'h20, 8'h00, 0);
		sys_try(8'h60, 8'h00, 1);
		sys_try(8'h6F, 8'h01, 1);
		ts_try(8'h08, 1'b1, 1'b1, 1'b1, 1'b1);
		ts_try(8'h08, 1'b1, 1'b1, 1'b0, 1'b0);
		ts_try(8'h08, 1'b0, 1'b1, 1'b1, 1'b0);
		ts_try(8'h08, 1'b1, 1'b0, 1'b1, 1'b0);
		ts_try(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
		ts_try(8'h09, 1'b1, 1'b1, 1'b0, 1'b1);
		// Second reset in mid run
		rst_b_in = 1'b0;
		ticks(2);
		rst_b_in = 1'b1;
		ticks(4);
		reset_values();
		test_done();
	end

	// ==========================================
	// Watchdog, about six times the expected run
	initial
	begin
		repeat (60000) @(posedge clock_in);
		failures++;
		test_done();
	end

endmodule
